// ### pkg/rqcr_pkg.sv
// shared constants and types for the requantizer configuration registers
package rqcr_pkg;

    // register addresses on the serial control port
    localparam logic [12:0] ADDR_USER_PATTERN_FOUR_HIGH = 13'h0020;
    localparam logic [12:0] ADDR_SELFTEST_SIG_LOW       = 13'h0024;
    localparam logic [12:0] ADDR_SELFTEST_SIG_HIGH      = 13'h0025;
    localparam logic [12:0] ADDR_REQUANTIZER_CONTROL    = 13'h003C;
    localparam logic [12:0] ADDR_REQUANTIZER_TUNING     = 13'h003E;

    // reset values
    localparam logic [7:0]  RST_USER_PATTERN_FOUR_HIGH  = 8'h00;
    localparam logic [15:0] RST_SELFTEST_SIGNATURE      = 16'h0000;
    localparam logic [7:0]  RST_REQUANTIZER_CONTROL     = 8'h00;
    localparam logic [7:0]  RST_REQUANTIZER_TUNING      = 8'h1C;

    // field positions
    localparam int CTL_ON_BIT      = 0;
    localparam int CTL_MODE_LSB    = 1;
    localparam int CTL_MODE_MSB    = 3;
    localparam int TUNE_POS_MSB    = 5;

    // band mode codes
    localparam logic [2:0] MODE_CODE_NARROW = 3'h0;
    localparam logic [2:0] MODE_CODE_WIDE   = 3'h1;

    // band widths and top tuning words in 0.5 % steps of the sample rate, plus tuning word counts
    localparam logic [6:0] NARROW_WIDTH_STEPS = 7'h2C;
    localparam logic [6:0] WIDE_WIDTH_STEPS   = 7'h42;
    localparam int         NARROW_SETTINGS    = 57;
    localparam int         WIDE_SETTINGS      = 34;
    localparam logic [5:0] NARROW_MAX_WORD    = 6'(NARROW_SETTINGS - 1);
    localparam logic [5:0] WIDE_MAX_WORD      = 6'(WIDE_SETTINGS - 1);

    // serial frame layout
    localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
    localparam logic [3:0] DATA_LAST_BIT  = 4'h7;
    localparam int         INSTR_RNW_BIT  = 15;

    typedef enum logic [1:0]
    {
        RQCR_ST_IDLE  = 2'b00,
        RQCR_ST_INSTR = 2'b01,
        RQCR_ST_DATA  = 2'b10
    } rqcr_port_state_t;

    typedef enum logic
    {
        RQCR_BAND_NARROW = 1'b0,
        RQCR_BAND_WIDE   = 1'b1
    } rqcr_band_t;

    typedef struct packed
    {
        logic        en;
        logic [12:0] addr;
        logic [7:0]  data;
    } rqcr_wr_t;

endpackage : rqcr_pkg

// ### logic/rqcr_serial_port.sv
// serial control port slave: instruction, address and data bytes
`timescale 1ns/1ps
module rqcr_serial_port
    import rqcr_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        sclk_i,
    input  wire logic        csb_i,
    input  wire logic        sdio_i,
    input  wire logic [7:0]  rdata_i,
    output rqcr_wr_t         wr_o,
    output logic [12:0]      rd_addr_o,
    output logic             sdio_o,
    output logic             sdio_oe_o
);

    rqcr_port_state_t st_r,     st_nxt;
    logic             sclk_q_r;
    logic [3:0]       cnt_r,    cnt_nxt;
    logic [15:0]      instr_r,  instr_nxt;
    logic [7:0]       in_sr_r,  in_sr_nxt;
    logic [7:0]       out_sr_r, out_sr_nxt;
    logic [12:0]      addr_r,   addr_nxt;
    logic             rnw_r,    rnw_nxt;
    logic             dout_r,   dout_nxt;
    logic             oe_r,     oe_nxt;
    rqcr_wr_t         wr_r,     wr_nxt;
    logic             rise;
    logic             fall;

    assign rise = sclk_i & ~sclk_q_r & ~csb_i;
    assign fall = ~sclk_i & sclk_q_r & ~csb_i;

    always_comb
    begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        instr_nxt  = instr_r;
        in_sr_nxt  = in_sr_r;
        out_sr_nxt = out_sr_r;
        addr_nxt   = addr_r;
        rnw_nxt    = rnw_r;
        dout_nxt   = dout_r;
        oe_nxt     = oe_r;
        wr_nxt     = '{en: 1'b0, addr: addr_r, data: in_sr_r};
        if (csb_i)
        begin
            st_nxt  = RQCR_ST_IDLE;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end
        else
        begin
            unique case (st_r)
                RQCR_ST_IDLE, RQCR_ST_INSTR:
                begin
                    st_nxt = RQCR_ST_INSTR;
                    if (rise)
                    begin
                        instr_nxt = {instr_r[14:0], sdio_i};
                        cnt_nxt   = cnt_r + 4'h1;
                        if (cnt_r == INSTR_LAST_BIT)
                        begin
                            st_nxt   = RQCR_ST_DATA;
                            cnt_nxt  = 4'h0;
                            rnw_nxt  = instr_r[INSTR_RNW_BIT - 1];
                            oe_nxt   = instr_r[INSTR_RNW_BIT - 1];
                            addr_nxt = {instr_r[11:0], sdio_i};
                        end
                    end
                end
                RQCR_ST_DATA:
                begin
                    if (fall && rnw_r)
                    begin
                        // first bit of each byte comes fresh from the register
                        if (cnt_r == 4'h0)
                        begin
                            dout_nxt   = rdata_i[7];
                            out_sr_nxt = {rdata_i[6:0], 1'b0};
                        end
                        else
                        begin
                            dout_nxt   = out_sr_r[7];
                            out_sr_nxt = {out_sr_r[6:0], 1'b0};
                        end
                    end
                    if (rise)
                    begin
                        in_sr_nxt = {in_sr_r[6:0], sdio_i};
                        cnt_nxt   = cnt_r + 4'h1;
                        if (cnt_r == DATA_LAST_BIT)
                        begin
                            cnt_nxt  = 4'h0;
                            addr_nxt = addr_r - 13'h0001;
                            wr_nxt   = '{en: ~rnw_r, addr: addr_r, data: {in_sr_r[6:0], sdio_i}};
                        end
                    end
                end
                default:
                begin
                    st_nxt = RQCR_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_r     <= RQCR_ST_IDLE;
            sclk_q_r <= 1'b0;
            cnt_r    <= 4'h0;
            instr_r  <= 16'h0000;
            in_sr_r  <= 8'h00;
            out_sr_r <= 8'h00;
            addr_r   <= 13'h0000;
            rnw_r    <= 1'b0;
            dout_r   <= 1'b0;
            oe_r     <= 1'b0;
            wr_r     <= '0;
        end
        else
        begin
            st_r     <= st_nxt;
            sclk_q_r <= sclk_i;
            cnt_r    <= cnt_nxt;
            instr_r  <= instr_nxt;
            in_sr_r  <= in_sr_nxt;
            out_sr_r <= out_sr_nxt;
            addr_r   <= addr_nxt;
            rnw_r    <= rnw_nxt;
            dout_r   <= dout_nxt;
            oe_r     <= oe_nxt;
            wr_r     <= wr_nxt;
        end
    end

    assign wr_o      = wr_r;
    assign rd_addr_o = addr_r;
    assign sdio_o    = dout_r;
    assign sdio_oe_o = oe_r;

endmodule : rqcr_serial_port

// ### logic/rqcr_regs.sv
// requantizer configuration and self-test readback registers behind the serial port
//
// Behaviour
// [RULE_01] control bits 3..1 choose the requantizer band mode
// [RULE_02] mode 000 gives narrow band, 22 % of the sample rate
// [RULE_03] mode 001 gives wide band, 33 % of the sample rate
// [RULE_04] control bit 0 turns the requantizer on; reset leaves it off
// [RULE_05] tuning bits 5..0 place the band edges; tuning resets to 1C
// [RULE_06] narrow mode accepts 57 tuning words
// [RULE_07] wide mode accepts 34 tuning words
// [RULE_08] each tuning step moves the band by 0.5 % of sample rate
// [RULE_09] host keeps the serial port quiet during critical sampling
// [RULE_10] signature bytes read only, reset zero, low byte at lower address
// [RULE_11] host writes only valid tuning words and zero reserved bits
`timescale 1ns/1ps
module rqcr_regs
    import rqcr_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        sclk_i,
    input  wire logic        csb_i,
    input  wire logic        sdio_i,
    output logic             sdio_o,
    output logic             sdio_oe_o,
    input  wire logic [15:0] selftest_signature_i,
    input  wire logic        selftest_done_i,
    output logic             requantizer_on_o,
    output logic [2:0]       requantizer_band_mode_o,
    output logic [5:0]       requantizer_band_position_o,
    output logic [6:0]       band_low_edge_o,
    output logic [6:0]       band_high_edge_o,
    output logic             band_position_valid_o,
    output logic [7:0]       user_pattern_four_high_o
);

    rqcr_wr_t    wr;
    logic [12:0] rd_addr;
    logic [7:0]  rdata;

    logic [7:0]  pattern_r, pattern_nxt;
    logic [3:0]  ctl_r,     ctl_nxt;
    logic [5:0]  tune_r,    tune_nxt;
    logic [15:0] sig_r,     sig_nxt;

    logic        on_r;
    logic [2:0]  mode_r;
    logic [5:0]  pos_r;
    logic [6:0]  low_r,     low_nxt;
    logic [6:0]  high_r,    high_nxt;
    logic        valid_r,   valid_nxt;

    // band class of a mode code; unknown codes fall back to narrow
    function automatic rqcr_band_t band_of(input logic [2:0] code);
        band_of = (code == MODE_CODE_WIDE) ? RQCR_BAND_WIDE : RQCR_BAND_NARROW;
    endfunction : band_of

    function automatic logic mode_known(input logic [2:0] code);
        mode_known = (code == MODE_CODE_NARROW) || (code == MODE_CODE_WIDE);
    endfunction : mode_known

    rqcr_serial_port u_port
    (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .sclk_i     (sclk_i),
        .csb_i      (csb_i),
        .sdio_i     (sdio_i),
        .rdata_i    (rdata),
        .wr_o       (wr),
        .rd_addr_o  (rd_addr),
        .sdio_o     (sdio_o),
        .sdio_oe_o  (sdio_oe_o)
    );

    // read decode, unmapped addresses read zero
    always_comb
    begin
        rdata = 8'h00;
        unique case (rd_addr)
            ADDR_USER_PATTERN_FOUR_HIGH: rdata = pattern_r;
            ADDR_SELFTEST_SIG_LOW:       rdata = sig_r[7:0];   // RULE_10
            ADDR_SELFTEST_SIG_HIGH:      rdata = sig_r[15:8];  // RULE_10
            ADDR_REQUANTIZER_CONTROL:    rdata = {4'h0, ctl_r};
            ADDR_REQUANTIZER_TUNING:     rdata = {2'h0, tune_r};
            default:                     rdata = 8'h00;
        endcase
    end

    // register writes; reserved bits are dropped
    always_comb
    begin
        pattern_nxt = pattern_r;
        ctl_nxt     = ctl_r;
        tune_nxt    = tune_r;
        sig_nxt     = sig_r;
        if (wr.en)
        begin
            unique case (wr.addr)
                ADDR_USER_PATTERN_FOUR_HIGH: pattern_nxt = wr.data;
                ADDR_REQUANTIZER_CONTROL:    ctl_nxt = wr.data[CTL_MODE_MSB:CTL_ON_BIT];  // RULE_01
                ADDR_REQUANTIZER_TUNING:     tune_nxt = wr.data[TUNE_POS_MSB:0];          // RULE_05 RULE_11
                default:                     pattern_nxt = pattern_r;
            endcase
        end
        // only the self-test engine updates the signature
        if (selftest_done_i)
        begin
            sig_nxt = selftest_signature_i;  // RULE_10
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pattern_r <= RST_USER_PATTERN_FOUR_HIGH;
            ctl_r     <= RST_REQUANTIZER_CONTROL[CTL_MODE_MSB:CTL_ON_BIT];  // RULE_04
            tune_r    <= RST_REQUANTIZER_TUNING[TUNE_POS_MSB:0];            // RULE_05
            sig_r     <= RST_SELFTEST_SIGNATURE;                            // RULE_10
        end
        else
        begin
            pattern_r <= pattern_nxt;
            ctl_r     <= ctl_nxt;
            tune_r    <= tune_nxt;
            sig_r     <= sig_nxt;
        end
    end

    // band edges in 0.5 % steps and tuning range check
    always_comb
    begin
        low_nxt   = {1'b0, tune_r};  // RULE_08
        high_nxt  = 7'h00;
        valid_nxt = 1'b0;
        unique case (band_of(ctl_r[CTL_MODE_MSB:CTL_MODE_LSB]))
            RQCR_BAND_NARROW:
            begin
                high_nxt  = {1'b0, tune_r} + NARROW_WIDTH_STEPS;  // RULE_02
                valid_nxt = (tune_r <= NARROW_MAX_WORD);          // RULE_06
            end
            RQCR_BAND_WIDE:
            begin
                high_nxt  = {1'b0, tune_r} + WIDE_WIDTH_STEPS;    // RULE_03
                valid_nxt = (tune_r <= WIDE_MAX_WORD);            // RULE_07
            end
        endcase
        valid_nxt = valid_nxt & mode_known(ctl_r[CTL_MODE_MSB:CTL_MODE_LSB]);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            on_r    <= 1'b0;
            mode_r  <= 3'h0;
            pos_r   <= 6'h00;
            low_r   <= 7'h00;
            high_r  <= 7'h00;
            valid_r <= 1'b0;
        end
        else
        begin
            on_r    <= ctl_r[CTL_ON_BIT];                    // RULE_04
            mode_r  <= ctl_r[CTL_MODE_MSB:CTL_MODE_LSB];     // RULE_01
            pos_r   <= tune_r;                               // RULE_05
            low_r   <= low_nxt;
            high_r  <= high_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign requantizer_on_o            = on_r;
    assign requantizer_band_mode_o     = mode_r;
    assign requantizer_band_position_o = pos_r;
    assign band_low_edge_o             = low_r;
    assign band_high_edge_o            = high_r;
    assign band_position_valid_o       = valid_r;
    assign user_pattern_four_high_o    = pattern_r;

    // checks
    sequence s_ctl_write;
        wr.en && (wr.addr == ADDR_REQUANTIZER_CONTROL);
    endsequence

    sequence s_ctl_settled;
        ##2 (requantizer_band_mode_o == $past(wr.data[CTL_MODE_MSB:CTL_MODE_LSB], 2));
    endsequence

    a_mode_field_map: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_01
        s_ctl_write |-> s_ctl_settled)
        else $error("band mode output does not follow control bits 3..1");

    a_narrow_width: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_02
        (requantizer_band_mode_o == MODE_CODE_NARROW) && $stable(requantizer_band_mode_o)
        && $stable(band_low_edge_o) && !$past(rst_i) |-> (band_high_edge_o - band_low_edge_o == 7'h2C))
        else $error("narrow band is not 44 half-percent steps wide");

    a_wide_width: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_03
        (requantizer_band_mode_o == MODE_CODE_WIDE) && $stable(requantizer_band_mode_o)
        && $stable(band_low_edge_o) |-> (band_high_edge_o - band_low_edge_o == 7'h42))
        else $error("wide band is not 66 half-percent steps wide");

    a_enable_bit: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_04
        s_ctl_write |-> ##2 (requantizer_on_o == $past(wr.data[CTL_ON_BIT], 2)))
        else $error("enable output does not follow control bit 0");

    a_reset_values: assert property (@(posedge core_clk_i) // RULE_05
        $past(rst_i) && !rst_i |-> (tune_r == 6'h1C) && (ctl_r == 4'h0))
        else $error("tuning or control reset value wrong");

    a_narrow_range: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_06
        (ctl_r[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_CODE_NARROW) |=> (band_position_valid_o == ($past(tune_r) <= 6'd56)))
        else $error("narrow mode range check wrong");

    a_wide_range: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_07
        (ctl_r[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_CODE_WIDE) |=> (band_position_valid_o == ($past(tune_r) <= 6'd33)))
        else $error("wide mode range check wrong");

    a_step_size: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_08
        wr.en && (wr.addr == ADDR_REQUANTIZER_TUNING) |-> ##2 (band_low_edge_o == {1'b0, $past(wr.data[5:0], 2)}))
        else $error("band edge does not move one half-percent step per word");

    a_sig_readonly: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_10
        !selftest_done_i |=> $stable(sig_r))
        else $error("signature changed without the self-test engine");

endmodule : rqcr_regs

// ### verif/rqcr_host_model.sv
// host controller model driving the serial control port
`timescale 1ns/1ps
module rqcr_host_model
    import rqcr_pkg::*;
#(
    parameter int PHASE_CLKS = 4
)
(
    input  wire logic core_clk_i,
    input  wire logic sdio_line_i,
    output logic      sclk_o,
    output logic      csb_o,
    output logic      sdio_o
);
    logic last_bit;

    initial
    begin
        sclk_o   = 1'b0;
        csb_o    = 1'b1;
        sdio_o   = 1'b0;
        last_bit = 1'b0;
    end

    task automatic hold_phase();
        repeat (PHASE_CLKS) @(negedge core_clk_i);
    endtask : hold_phase

    // bit set up while sclk is low, taken on the rise
    task automatic send_bit(input logic b);
        sclk_o   = 1'b0;
        sdio_o   = b;
        last_bit = b;
        hold_phase();
        sclk_o = 1'b1;
        hold_phase();
    endtask : send_bit

    // line released: toggle so no stale level is left behind
    task automatic recv_bit(output logic b);
        sclk_o = 1'b0;
        sdio_o = ~sdio_o;
        hold_phase();
        b      = sdio_line_i;
        sclk_o = 1'b1;
        hold_phase();
    endtask : recv_bit

    // one frame: instruction, then n bytes msb first
    task automatic xfer(input logic rnw, input logic [12:0] addr, input int n,
                        input logic [15:0] wdata, output logic [15:0] rdata);
        logic [15:0] instr;
        logic        b;
        instr = {rnw, 2'b00, addr};
        rdata = 16'h0000;
        @(negedge core_clk_i);
        csb_o = 1'b0;
        hold_phase();
        for (int i = 15; i >= 0; i--)
            send_bit(instr[i]);
        for (int i = 8 * n - 1; i >= 0; i--)
        begin
            if (rnw)
            begin
                recv_bit(b);
                rdata[i] = b;
            end
            else
                send_bit(wdata[i]);
        end
        sclk_o = 1'b0;
        hold_phase();
        csb_o  = 1'b1;
        sdio_o = ~last_bit;
        hold_phase();
    endtask : xfer
endmodule : rqcr_host_model

// ### verif/requantizer_config_registers_tb_top.sv
// testbench for the requantizer configuration registers
`timescale 1ns/1ps
module requantizer_config_registers_tb_top;
    import rqcr_pkg::*;

    localparam int CYC_LIMIT = 40000;

    logic        core_clk;
    logic        rst;
    logic        sclk;
    logic        csb;
    logic        host_sdio;
    logic        dut_sdio;
    logic        dut_oe;
    logic        sdio_line;
    logic [15:0] sig;
    logic        sig_done;
    logic        on;
    logic [2:0]  mode;
    logic [5:0]  pos;
    logic [6:0]  low;
    logic [6:0]  high;
    logic        pvalid;
    logic [7:0]  pattern;
    int          err_total;
    int          cmp_count;
    int          cyc;
    logic [2:0]  t_mode [4];
    logic [5:0]  t_word [4];
    logic        t_on   [4];

    assign sdio_line = dut_oe ? dut_sdio : host_sdio;

    rqcr_regs u_dut (
        .core_clk_i                  (core_clk),
        .rst_i                       (rst),
        .sclk_i                      (sclk),
        .csb_i                       (csb),
        .sdio_i                      (sdio_line),
        .sdio_o                      (dut_sdio),
        .sdio_oe_o                   (dut_oe),
        .selftest_signature_i        (sig),
        .selftest_done_i             (sig_done),
        .requantizer_on_o            (on),
        .requantizer_band_mode_o     (mode),
        .requantizer_band_position_o (pos),
        .band_low_edge_o             (low),
        .band_high_edge_o            (high),
        .band_position_valid_o       (pvalid),
        .user_pattern_four_high_o    (pattern)
    );

    rqcr_host_model u_host (
        .core_clk_i  (core_clk),
        .sdio_line_i (sdio_line),
        .sclk_o      (sclk),
        .csb_o       (csb),
        .sdio_o      (host_sdio)
    );

    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == CYC_LIMIT)
        begin
            err_total++;
            results();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr8(input logic [12:0] a, input logic [7:0] d);
        logic [15:0] r;
        u_host.xfer(1'b0, a, 1, {8'h00, d}, r);
        repeat (4) @(negedge core_clk);
    endtask : wr8

    task automatic rd_chk(input string what, input logic [12:0] a, input int n, input logic [15:0] exp);
        logic [15:0] r;
        u_host.xfer(1'b1, a, n, 16'h0000, r);
        check(what, r, exp);
    endtask : rd_chk

    // band outputs against mode, word and enable
    task automatic chk_outs(input logic exp_on, input logic [2:0] exp_mode, input logic [5:0] word);
        logic [6:0] span;
        span = (exp_mode == MODE_CODE_WIDE) ? WIDE_WIDTH_STEPS : NARROW_WIDTH_STEPS;
        check("on", {15'h0000, on}, {15'h0000, exp_on});
        check("mode", {13'h0000, mode}, {13'h0000, exp_mode});
        check("position", {10'h000, pos}, {10'h000, word});
        check("low_edge", {9'h000, low}, {9'h000, 1'b0, word});
        check("high_edge", {9'h000, high}, {9'h000, {1'b0, word} + span});
        check("valid", {15'h0000, pvalid}, 16'h0001);
    endtask : chk_outs

    initial
    begin
        rst       = 1'b1;
        sig       = 16'h0000;
        sig_done  = 1'b0;
        err_total = 0;
        cmp_count = 0;
        cyc       = 0;
        t_mode    = '{MODE_CODE_NARROW, MODE_CODE_NARROW, MODE_CODE_WIDE, MODE_CODE_WIDE};
        t_word    = '{NARROW_MAX_WORD, 6'h00, WIDE_MAX_WORD, 6'h00};
        t_on      = '{1'b1, 1'b0, 1'b1, 1'b1};
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_outs(1'b0, MODE_CODE_NARROW, 6'h1C);
        rd_chk("pattern_rst", ADDR_USER_PATTERN_FOUR_HIGH, 1, 16'h0000);
        rd_chk("sig_low_rst", ADDR_SELFTEST_SIG_LOW, 1, 16'h0000);
        rd_chk("sig_high_rst", ADDR_SELFTEST_SIG_HIGH, 1, 16'h0000);
        rd_chk("control_rst", ADDR_REQUANTIZER_CONTROL, 1, 16'h0000);
        rd_chk("tuning_rst", ADDR_REQUANTIZER_TUNING, 1, 16'h001C);
        rd_chk("unmapped", 13'h0021, 1, 16'h0000);
        // both modes at the ends of their tuning ranges
        for (int i = 0; i < 4; i++)
        begin
            wr8(ADDR_REQUANTIZER_CONTROL, {4'h0, t_mode[i], t_on[i]});
            wr8(ADDR_REQUANTIZER_TUNING, {2'b00, t_word[i]});
            chk_outs(t_on[i], t_mode[i], t_word[i]);
            rd_chk("control", ADDR_REQUANTIZER_CONTROL, 1, {12'h000, t_mode[i], t_on[i]});
            rd_chk("tuning", ADDR_REQUANTIZER_TUNING, 1, {10'h000, t_word[i]});
        end
        // an undecoded mode code falls back to narrow edges and reports not valid
        wr8(ADDR_REQUANTIZER_CONTROL, 8'h04);
        check("mode_unknown", {13'h0000, mode}, 16'h0002);
        check("on_unknown", {15'h0000, on}, 16'h0000);
        check("valid_unknown", {15'h0000, pvalid}, 16'h0000);
        check("high_unknown", {9'h000, high}, {9'h000, NARROW_WIDTH_STEPS});
        check("oe_idle", {15'h0000, dut_oe}, 16'h0000);
        // signature capture, streamed high then low byte
        sig      = 16'hA55A;
        sig_done = 1'b1;
        @(negedge core_clk);
        sig_done = 1'b0;
        sig      = 16'h0F0F;
        rd_chk("signature", ADDR_SELFTEST_SIG_HIGH, 2, 16'hA55A);
        wr8(ADDR_SELFTEST_SIG_LOW, 8'hFF);
        wr8(ADDR_SELFTEST_SIG_HIGH, 8'hFF);
        rd_chk("signature_ro", ADDR_SELFTEST_SIG_HIGH, 2, 16'hA55A);
        wr8(ADDR_USER_PATTERN_FOUR_HIGH, 8'hC3);
        check("pattern_out", {8'h00, pattern}, 16'h00C3);
        rd_chk("pattern", ADDR_USER_PATTERN_FOUR_HIGH, 1, 16'h00C3);
        // second reset in mid-run
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_outs(1'b0, MODE_CODE_NARROW, 6'h1C);
        rd_chk("sig_low_rst2", ADDR_SELFTEST_SIG_LOW, 1, 16'h0000);
        results();
    end
endmodule : requantizer_config_registers_tb_top
